// *** design/timer_combination_mode.sv ***
// Function control, output master enable and external trigger logic for timer channels 3 and 4.
// Assumes an APB master on clk_sys; counter, compare and capture datapaths sit outside and feed the
// per-pin timer requests, the capture event and standby entry.
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ns
`include "timer_combo_defs.svh"

module timer_combination_mode (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic standbyEntry,
   input wire logic ch1CaptureA,
   input wire logic ch3SyncSelect,
   input wire logic ch4SyncSelect,
   input wire logic [5:0] timerDriveReq,
   output timer_combo_pkg::combo_mode_type comboMode,
   output logic ch3PwmEffective,
   output logic ch4PwmEffective,
   output logic ch3SyncEffective,
   output logic ch4SyncEffective,
   output timer_combo_pkg::buffer_sel_type bufferSelect,
   output logic [5:0] pinTimerOwned
);
   // ===================================================================
   // Bus decode
   logic [7:0] funcCtrl_q, funcCtrl_d;
   logic [7:0] outEnable_q, outEnable_d;
   logic [7:0] trigCtrl_q, trigCtrl_d;
   logic [7:0] modeSel_q, modeSel_d;
   logic [1:0] capSync_q, capSync_d;
   logic capPrev_q, capPrev_d;
   logic [31:0] prdata_q, prdata_d;
   logic accessWrite;
   logic accessRead;
   logic jointPwm;
   logic trigClear;

   assign accessWrite = psel && penable && pwrite;
   assign accessRead = psel && penable && !pwrite;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign prdata = prdata_q;

   // ===================================================================
   // Mode decode
   assign comboMode = timer_combo_pkg::combo_mode_type'(funcCtrl_q[`CMODE_HI_BIT:`CMODE_LO_BIT]);
   assign jointPwm = funcCtrl_q[`CMODE_HI_BIT];
   assign ch3PwmEffective = modeSel_q[0] && !jointPwm;
   assign ch4PwmEffective = modeSel_q[1] && !jointPwm;
   assign ch3SyncEffective = ch3SyncSelect;
   assign ch4SyncEffective = ch4SyncSelect;
   assign bufferSelect.ch4RegB = funcCtrl_q[3];
   assign bufferSelect.ch4RegA = funcCtrl_q[2];
   assign bufferSelect.ch3RegB = funcCtrl_q[1];
   assign bufferSelect.ch3RegA = funcCtrl_q[0];

   // Pin i is timer-driven only when its enable and the timer request both stand
   genvar i;
   generate
      for (i = 0; i < `PINS; i++) begin : gPin
         assign pinTimerOwned[i] = outEnable_q[i] && timerDriveReq[i];
      end
   endgenerate

   // ===================================================================
   // Trigger detect: capture pulse from the capture logic, resynchronised
   assign trigClear = capSync_q[1] && !capPrev_q && !trigCtrl_q[`TRIG_DISABLE_BIT] && jointPwm;

   // ===================================================================
   // Register next state
   always_comb begin
      funcCtrl_d = funcCtrl_q;
      outEnable_d = outEnable_q;
      trigCtrl_d = trigCtrl_q;
      modeSel_d = modeSel_q;
      capSync_d = {capSync_q[0], ch1CaptureA};
      capPrev_d = capSync_q[1];
      prdata_d = 32'h0000_0000;
      if (accessWrite) begin
         case (paddr)
            `FUNC_CTRL_OFFSET: funcCtrl_d = pwdata[7:0] | `FIXED_ONES_MASK;
            `OUT_ENABLE_OFFSET: outEnable_d = pwdata[7:0] | `FIXED_ONES_MASK;
            `TRIG_CTRL_OFFSET: trigCtrl_d = pwdata[7:0] | `TRIG_FIXED_MASK;
            `MODE_SEL_OFFSET: modeSel_d = {6'h00, pwdata[1:0]};
            default: ;
         endcase
      end
      if (trigClear) begin
         outEnable_d = outEnable_q & ~`ENABLE_FIELD_MASK;
      end
      if (standbyEntry) begin
         funcCtrl_d = `FUNC_CTRL_RESET;
         outEnable_d = `OUT_ENABLE_RESET;
         trigCtrl_d = `TRIG_CTRL_RESET;
         modeSel_d = `MODE_SEL_RESET;
      end
      if (accessRead) begin
         case (paddr)
            `FUNC_CTRL_OFFSET: prdata_d = {24'h000000, funcCtrl_q};
            `OUT_ENABLE_OFFSET: prdata_d = {24'h000000, outEnable_q};
            `TRIG_CTRL_OFFSET: prdata_d = {24'h000000, trigCtrl_q};
            `MODE_SEL_OFFSET: prdata_d = {24'h000000, modeSel_q};
            `STATUS_OFFSET: prdata_d = {26'h0000000, pinTimerOwned};
            default: prdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         funcCtrl_q <= `FUNC_CTRL_RESET;
         outEnable_q <= `OUT_ENABLE_RESET;
         trigCtrl_q <= `TRIG_CTRL_RESET;
         modeSel_q <= `MODE_SEL_RESET;
         capSync_q <= 2'h0;
         capPrev_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         funcCtrl_q <= funcCtrl_d;
         outEnable_q <= outEnable_d;
         trigCtrl_q <= trigCtrl_d;
         modeSel_q <= modeSel_d;
         capSync_q <= capSync_d;
         capPrev_q <= capPrev_d;
         prdata_q <= prdata_d;
      end
   end

   // ===================================================================
   // Assertions
   fixed_ones_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      funcCtrl_q[7:6] == 2'h3 && outEnable_q[7:6] == 2'h3) else $error("reserved bits not one");
   standby_load_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      standbyEntry |=> funcCtrl_q == 8'hC0) else $error("function control not reloaded");
   standby_enable_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      standbyEntry |=> outEnable_q == 8'hFF) else $error("enables not reloaded");
   pwm_override_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      jointPwm |-> !ch3PwmEffective && !ch4PwmEffective) else $error("pwm select not overridden");
   trig_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      trigClear && !standbyEntry |=> outEnable_q[5:0] == 6'h00) else $error("trigger did not clear");
   clear_wins_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      trigClear && accessWrite && !standbyEntry |=> outEnable_q[5:0] == 6'h00) else $error("write beat clear");
   normal_no_trig_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !jointPwm |-> !trigClear) else $error("trigger outside joint pwm");
   pin_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !outEnable_q[5] |-> !pinTimerOwned[5]) else $error("pin owned while disabled");
   buffer_map_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      bufferSelect.ch4RegB == funcCtrl_q[3] && bufferSelect.ch3RegA == funcCtrl_q[0]) else $error("buffer map");
   cov_comp: cover property (@(posedge clk_sys) disable iff (!rst_b) comboMode == timer_combo_pkg::MODE_COMPLEMENTARY);
   cov_trig: cover property (@(posedge clk_sys) disable iff (!rst_b) trigClear);
   cov_clash: cover property (@(posedge clk_sys) disable iff (!rst_b) trigClear && accessWrite);
   cov_rsync: cover property (@(posedge clk_sys) disable iff (!rst_b) comboMode == timer_combo_pkg::MODE_RESET_SYNC);
   cov_standby: cover property (@(posedge clk_sys) disable iff (!rst_b) standbyEntry && outEnable_q != 8'hFF);

   // ===================================================================
   // Mode and buffer select checks
   comp_mode_a: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      funcCtrl_q[5:4] == 2'h2 |-> comboMode == timer_combo_pkg::MODE_COMPLEMENTARY)
      else $error("complementary mode not decoded");
   rsync_mode_a: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      funcCtrl_q[5:4] == 2'h3 |-> comboMode == timer_combo_pkg::MODE_RESET_SYNC)
      else $error("reset sync mode not decoded");
   normal_mode_a: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      !funcCtrl_q[5] |-> !jointPwm)
      else $error("normal mode taken as joint pwm");
   ch3_pwm_select_pass_a: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      !jointPwm |-> ch3PwmEffective == modeSel_q[0])
      else $error("channel 3 pwm select lost");
   ch4_pwm_select_pass_a: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      !jointPwm |-> ch4PwmEffective == modeSel_q[1])
      else $error("channel 4 pwm select lost");
   ch3_sync_select_keep_a: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      ch3SyncEffective == ch3SyncSelect)
      else $error("channel 3 sync dropped");
   ch4_sync_select_keep_a: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      ch4SyncEffective == ch4SyncSelect)
      else $error("channel 4 sync dropped");
   buf_b4_a: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      bufferSelect.ch4RegB == funcCtrl_q[3])
      else $error("channel 4 B buffer select wrong");
   buf_a4_a: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      bufferSelect.ch4RegA == funcCtrl_q[2])
      else $error("channel 4 A buffer select wrong");
   buf_b3_a: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      bufferSelect.ch3RegB == funcCtrl_q[1])
      else $error("channel 3 B buffer select wrong");
   buf_a3_a: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      bufferSelect.ch3RegA == funcCtrl_q[0])
      else $error("channel 3 A buffer select wrong");

   // ===================================================================
   // Pin gating checks
   gate_cxb4_a: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      pinTimerOwned[5] == (outEnable_q[5] && timerDriveReq[5]))
      else $error("complement pin B gating wrong");
   gate_cxa4_a: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      pinTimerOwned[4] == (outEnable_q[4] && timerDriveReq[4]))
      else $error("complement pin A gating wrong");
   gate_b3_a: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      pinTimerOwned[3] == (outEnable_q[3] && timerDriveReq[3]))
      else $error("channel 3 pin B gating wrong");
   gate_b4_a: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      pinTimerOwned[2] == (outEnable_q[2] && timerDriveReq[2]))
      else $error("channel 4 pin B gating wrong");
   gate_a4_a: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      pinTimerOwned[1] == (outEnable_q[1] && timerDriveReq[1]))
      else $error("channel 4 pin A gating wrong");

   // ===================================================================
   // Register and trigger checks
   trig_disabled_a: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      trigCtrl_q[`TRIG_DISABLE_BIT] |-> !trigClear)
      else $error("trigger acted while disabled");
   trig_enable_a: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      trigClear |-> !trigCtrl_q[`TRIG_DISABLE_BIT])
      else $error("trigger without enable");
   trig_fixed_a: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      trigCtrl_q[7:5] == 3'h7 && trigCtrl_q[3:0] == 4'hF)
      else $error("trigger control fixed bits not one");
   trig_edge_a: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      trigClear |-> capSync_q[1] && !capPrev_q)
      else $error("trigger without capture edge");
   trig_mode_a: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      trigClear |-> funcCtrl_q[`CMODE_HI_BIT])
      else $error("trigger in normal mode");
   func_write_a: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      accessWrite && paddr == `FUNC_CTRL_OFFSET && !standbyEntry |=> funcCtrl_q == ($past(pwdata[7:0]) | 8'hC0))
      else $error("function control write lost");
   enable_write_a: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      accessWrite && paddr == `OUT_ENABLE_OFFSET && !trigClear && !standbyEntry
      |=> outEnable_q == ($past(pwdata[7:0]) | 8'hC0))
      else $error("output enable write lost");
   func_hold_a: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      !accessWrite && !standbyEntry |=> $stable(funcCtrl_q))
      else $error("function control changed unasked");
   enable_hold_a: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      !accessWrite && !trigClear && !standbyEntry |=> $stable(outEnable_q))
      else $error("output enable changed unasked");
   standby_wins_a: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      standbyEntry && trigClear |=> outEnable_q == 8'hFF)
      else $error("standby lost to trigger");
   clear_top_a: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      trigClear |=> outEnable_q[7:6] == 2'h3)
      else $error("trigger cleared fixed bits");
   read_fixed_a: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      accessRead && paddr == `FUNC_CTRL_OFFSET |=> prdata[7:6] == 2'h3)
      else $error("fixed bits read zero");
endmodule : timer_combination_mode

// *** design/timer_combo_defs.svh ***
// Register offsets, field positions, reset values for the channel 3/4 combination control block.
// Assumes inclusion by bare name from the design module.
`ifndef TIMER_COMBO_DEFS_SVH
`define TIMER_COMBO_DEFS_SVH
`define FUNC_CTRL_OFFSET 12'h000
`define OUT_ENABLE_OFFSET 12'h004
`define TRIG_CTRL_OFFSET 12'h008
`define MODE_SEL_OFFSET 12'h00C
`define STATUS_OFFSET 12'h010
`define FUNC_CTRL_RESET 8'hC0
`define OUT_ENABLE_RESET 8'hFF
`define TRIG_CTRL_RESET 8'hFF
`define MODE_SEL_RESET 8'h00
`define FIXED_ONES_MASK 8'hC0
`define TRIG_FIXED_MASK 8'hEF
`define CMODE_HI_BIT 5
`define CMODE_LO_BIT 4
`define TRIG_DISABLE_BIT 4
`define ENABLE_FIELD_MASK 8'h3F
`define PINS 6
`endif

// *** design/timer_combo_pkg.sv ***
// Types for the channel 3/4 combination control block.
// Assumes nothing beyond the defines header.
package timer_combo_pkg;
   typedef enum logic [1:0] {
      MODE_NORMAL = 2'h0,
      MODE_NORMAL_ALT = 2'h1,
      MODE_COMPLEMENTARY = 2'h2,
      MODE_RESET_SYNC = 2'h3
   } combo_mode_type;

   typedef struct packed {
      logic [5:0] outEnable;
      logic [5:0] pinTimerOwned;
   } pin_ctrl_type;

   typedef struct packed {
      logic ch4RegB;
      logic ch4RegA;
      logic ch3RegB;
      logic ch3RegA;
   } buffer_sel_type;
endpackage : timer_combo_pkg

// *** verif/power_stage_model.sv ***
// Behavioural power switching stage fed by the channel 3/4 pins.
// Assumes pinTimerOwned from the combination block, sampled on clk_sys.
`timescale 1ns/1ns
// ==========================================
// Power stage model
module power_stage_model (
   input wire logic clk_sys,
   input wire logic [5:0] pinTimerOwned,
   output logic [5:0] gateOn
);
   // Gate drivers follow pin ownership one clock later
   always_ff @(posedge clk_sys) begin
      gateOn <= pinTimerOwned;
   end
endmodule : power_stage_model

// *** verif/timer_combination_mode_tb.sv ***
// Self-checking bench for the channel 3/4 combination control block.
// Assumes the zero-wait APB slave with registered read data of the design.
`timescale 1ns/1ns
module timer_combination_mode_tb;
   logic clk_sys = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata;
   logic pready, pslverr, standbyEntry = 0, ch1CaptureA = 0;
   logic ch3SyncSelect = 1, ch4SyncSelect = 0, ch3PwmEffective, ch4PwmEffective;
   logic ch3SyncEffective, ch4SyncEffective;
   logic [5:0] timerDriveReq = 6'h3F, pinTimerOwned, gateOn;
   timer_combo_pkg::combo_mode_type comboMode;
   timer_combo_pkg::buffer_sel_type bufferSelect;
   int failures = 0, compares = 0;
   always #20 clk_sys = ~clk_sys;
   timer_combination_mode i_timer_combination_mode (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .standbyEntry(standbyEntry), .ch1CaptureA(ch1CaptureA),
      .ch3SyncSelect(ch3SyncSelect), .ch4SyncSelect(ch4SyncSelect), .timerDriveReq(timerDriveReq),
      .comboMode(comboMode), .ch3PwmEffective(ch3PwmEffective), .ch4PwmEffective(ch4PwmEffective),
      .ch3SyncEffective(ch3SyncEffective), .ch4SyncEffective(ch4SyncEffective),
      .bufferSelect(bufferSelect), .pinTimerOwned(pinTimerOwned));
   power_stage_model i_power_stage_model (.clk_sys(clk_sys), .pinTimerOwned(pinTimerOwned), .gateOn(gateOn));
   // ==========================================
   // Bus and compare tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      psel <= 1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk_sys);
      penable <= 1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      psel <= 0;
      penable <= 0;
      #1;
   endtask : xfer
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      xfer(1, a, d);
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      xfer(0, a, 8'h00);
      chk(prdata, exp);
   endtask : rd
   task automatic capture;
      @(posedge clk_sys);
      ch1CaptureA <= 1;
      repeat (2) @(posedge clk_sys);
      ch1CaptureA <= 0;
      repeat (4) @(posedge clk_sys);
      #1;
   endtask : capture
   task automatic print_verdict;
      $display("compares=%0d failures=%0d", compares, failures);
      if (failures == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : print_verdict
   // ==========================================
   // Tests
   initial begin
      repeat (20) @(posedge clk_sys);
      rst_b <= 1;
      rd(12'h000, 32'hC0);
      rd(12'h004, 32'hFF);
      wr(12'h000, 8'h00);
      rd(12'h000, 32'hC0);
      wr(12'h004, 8'h00);
      rd(12'h004, 32'hC0);
      for (int i = 0; i < 4; i++) begin
         wr(12'h000, 8'(1 << i));
         chk({28'h0, bufferSelect}, 32'(1 << i));
      end
      wr(12'h00C, 8'h03);
      for (int m = 0; m < 4; m++) begin
         // Counters are held stopped while the mode changes; sync bits never both set
         wr(12'h000, 8'(8'hC0 | (m << 4)));
         chk({30'h0, comboMode}, 32'(m));
         chk({30'h0, ch4PwmEffective, ch3PwmEffective}, m[1] ? 32'h0 : 32'h3);
         chk({30'h0, ch4SyncEffective, ch3SyncEffective}, 32'h1);
      end
      for (int i = 0; i < 6; i++) begin
         wr(12'h004, 8'(1 << i));
         @(posedge clk_sys);
         #1;
         chk({26'h0, pinTimerOwned}, 32'(1 << i));
         chk({26'h0, gateOn}, 32'(1 << i));
      end
      rd(12'h010, 32'h20);
      chk({30'h0, pready, pslverr}, 32'h2);
      wr(12'h008, 8'h00);
      rd(12'h008, 32'hEF);
      wr(12'h000, 8'hC0);
      wr(12'h004, 8'hFF);
      capture();
      rd(12'h004, 32'hFF);
      wr(12'h000, 8'hE0);
      capture();
      rd(12'h004, 32'hC0);
      wr(12'h004, 8'hFF);
      wr(12'h008, 8'hFF);
      capture();
      rd(12'h004, 32'hFF);
      wr(12'h000, 8'h3F);
      wr(12'h004, 8'h00);
      @(posedge clk_sys);
      standbyEntry <= 1;
      @(posedge clk_sys);
      standbyEntry <= 0;
      @(posedge clk_sys);
      rd(12'h000, 32'hC0);
      rd(12'h004, 32'hFF);
      wr(12'h020, 8'h55);
      rd(12'h020, 32'h0);
      print_verdict();
   end
   initial begin
      #100000;
      failures++;
      print_verdict();
   end
endmodule : timer_combination_mode_tb
